// ---- soc_pkg.sv ----
package soc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STANDBY = 8'h00;
  localparam logic [7:0] ADDR_MSTART  = 8'h01;
  localparam logic [7:0] ADDR_MODE    = 8'h02;
  localparam logic [7:0] ADDR_RATE    = 8'h03;
  localparam logic [7:0] ADDR_LANES   = 8'h04;
  localparam logic [7:0] ADDR_HOLD    = 8'h0c;
  localparam logic [7:0] ADDR_ADC_W   = 8'h14;
  localparam logic [7:0] ADDR_OUT_W   = 8'h1c;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and status bits
  // ----------------------------------------------------------------
  localparam logic       RST_HOLD     = 1'b1;
  localparam logic       RST_WIDTH    = 1'b1;
  localparam logic       RST_STANDBY  = 1'b1;
  localparam logic       RST_MSTART_N = 1'b1;
  localparam logic [1:0] RST_MODE     = 2'h0;
  localparam logic [1:0] RST_RATE     = 2'h0;
  localparam logic [2:0] RST_LANES    = 3'h1;
  localparam int         ST_STANDBY   = 0;
  localparam int         ST_MASTER    = 1;
  localparam int         ST_ILLEGAL   = 2;
  localparam int         ST_PENDING   = 3;
  localparam int         ST_WIDE      = 4;

  // ----------------------------------------------------------------
  // Pixel code range and sync words
  // ----------------------------------------------------------------
  localparam logic [11:0] PIX_MIN     = 12'h001;
  localparam logic [11:0] PIX_MAX10   = 12'h3fe;
  localparam logic [11:0] PIX_MAX12   = 12'hffe;
  localparam logic [11:0] SYNC_ONES10 = 12'h3ff;
  localparam logic [11:0] SYNC_ONES12 = 12'hfff;
  localparam logic [11:0] SYNC_XY10   = 12'h200;
  localparam logic [11:0] SYNC_XY12   = 12'h800;
  localparam logic [2:0]  SYNC_WORDS  = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int CLEAR_MIN_NS    = 500;
  localparam int CLEAR_CYCLES    = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REG_WAIT_NS     = 2000;
  localparam int REG_WAIT_CYCLES = (REG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_WARMUP      = 4;

  typedef enum logic [1:0] {MODE_WUXGA, MODE_UXGA, MODE_FHD, MODE_ROI} soc_mode_t;

  // Mode pairs that may change without a pass through standby
  function automatic logic soc_mode_direct(input logic [1:0] old_m, input logic [1:0] new_m);
    logic full_old;
    logic full_new;
    full_old = (old_m == MODE_WUXGA) || (old_m == MODE_UXGA);
    full_new = (new_m == MODE_WUXGA) || (new_m == MODE_UXGA);
    soc_mode_direct = (old_m == new_m) || (old_m == MODE_ROI && full_new) ||
                      (new_m == MODE_ROI && full_old);
  endfunction : soc_mode_direct

endpackage : soc_pkg

// ---- soc_if.sv ----
`timescale 1ns/1ps
interface soc_if;
  logic       system_clear_n;
  logic       comm_enable_n;
  logic       input_clock;
  logic       wr_valid;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  modport dev  (input  system_clear_n, comm_enable_n, input_clock, wr_valid, addr, wr_data,
                output rd_data);
  modport host (output system_clear_n, comm_enable_n, input_clock, wr_valid, addr, wr_data,
                input  rd_data);
endinterface : soc_if

// ---- soc_pixel_fmt.sv ----
`timescale 1ns/1ps
module soc_pixel_fmt
  import soc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        wide_in,
  input  wire logic        sync_en_in,
  input  wire logic [1:0]  sync_idx_in,
  input  wire logic [11:0] sample_in,
  input  wire logic        sample_valid_in,
  output logic      [11:0] word_out,
  output logic             valid_out,
  output logic             sync_out
);
  logic [11:0] word_next;
  logic        valid_next;
  logic        sync_next;
  logic [11:0] s;
  logic [11:0] vmax;

  always_comb begin
    vmax       = wide_in ? PIX_MAX12 : PIX_MAX10;
    s          = wide_in ? sample_in : {2'h0, sample_in[9:0]};
    word_next  = 12'h000;
    valid_next = 1'b0;
    sync_next  = 1'b0;
    if (sync_en_in) begin
      valid_next = 1'b1;
      sync_next  = 1'b1;
      case (sync_idx_in)
        2'h0:    word_next = wide_in ? SYNC_ONES12 : SYNC_ONES10;
        2'h1:    word_next = 12'h000;
        2'h2:    word_next = 12'h000;
        default: word_next = wide_in ? SYNC_XY12 : SYNC_XY10;
      endcase
    end else if (sample_valid_in) begin
      valid_next = 1'b1;
      if (s < PIX_MIN) word_next = PIX_MIN;
      else if (s > vmax) word_next = vmax;
      else word_next = s;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      word_out  <= 12'h000;
      valid_out <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      word_out  <= word_next;
      valid_out <= valid_next;
      sync_out  <= sync_next;
    end
  end
endmodule : soc_pixel_fmt

// ---- soc_device_end.sv ----
`timescale 1ns/1ps
// Behaviour
// - Both width fields equal; 0=10-bit, 1=12-bit
// - Pixel codes clamped to 001h..3FEh/FFEh
// - All-zero/all-one codes only in sync words
// - Hold set: later writes withheld from update
// - Hold cleared: held writes apply together
// - Hold flag defaults to active after clear
// - ROI to/from full modes change directly
// - Other changes need standby first
// - Glitchy clock change done under clear
// - System clear loads all register defaults
// - Clear held low at least 500 ns
// - Comm enable high until clock runs
// - Input clock starts after clear release
// - Register setup only after system clear
// - Standby bit 1 saves power; 0 restarts
// - Master start 0 after regulator wait
// - Standby from master also writes start 1
// - Sync words sized to selected width
module soc_device_end
  import soc_pkg::*;
#(
  parameter int FRAME_CYCLES = 1000
)(
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  soc_if.dev               link,
  input  wire logic        master_mode_in,
  input  wire logic        slave_vsync_in,
  input  wire logic [11:0] sample_in,
  input  wire logic        sample_valid_in,
  output logic      [11:0] pix_word_out,
  output logic             pix_valid_out,
  output logic             pix_sync_out,
  output logic      [1:0]  mode_out,
  output logic      [1:0]  rate_out,
  output logic      [2:0]  lanes_out,
  output logic             standby_out
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic       clr;
  logic       wr_ok;
  logic       upd;
  logic       tick;
  logic       inclk_q_reg,  seen_reg,     seen_next;
  logic       hold_reg,     hold_next;
  logic       stby_reg,     stby_next;
  logic       mst_n_reg,    mst_n_next;
  logic       p_adc_reg,    p_adc_next,   a_adc_reg,  a_adc_next;
  logic       p_out_reg,    p_out_next,   a_out_reg,  a_out_next;
  logic [1:0] p_mode_reg,   p_mode_next,  a_mode_reg, a_mode_next;
  logic [1:0] p_rate_reg,   p_rate_next,  a_rate_reg, a_rate_next;
  logic [2:0] p_lanes_reg,  p_lanes_next, a_lanes_reg, a_lanes_next;
  logic       pend_reg,     pend_next;
  logic       illegal_reg,  illegal_next;
  logic [7:0] rd_reg,       rd_next;
  logic [7:0] status;
  logic       ill_set;

  assign clr   = srst_in | ~link.system_clear_n;
  assign wr_ok = link.wr_valid & ~link.comm_enable_n & seen_reg;
  // In standby no frames run, so with hold cleared settings apply one cycle after the write
  assign upd   = ~hold_reg & (tick | stby_reg);

  always_comb begin
    status             = 8'h00;
    status[ST_STANDBY] = stby_reg;
    status[ST_MASTER]  = ~mst_n_reg & master_mode_in & ~stby_reg;
    status[ST_ILLEGAL] = illegal_reg;
    status[ST_PENDING] = pend_reg;
    status[ST_WIDE]    = a_out_reg;
  end

  always_comb begin
    seen_next    = seen_reg | (link.input_clock ^ inclk_q_reg);
    hold_next    = hold_reg;
    stby_next    = stby_reg;
    mst_n_next   = mst_n_reg;
    p_adc_next   = p_adc_reg;
    p_out_next   = p_out_reg;
    p_mode_next  = p_mode_reg;
    p_rate_next  = p_rate_reg;
    p_lanes_next = p_lanes_reg;
    a_adc_next   = a_adc_reg;
    a_out_next   = a_out_reg;
    a_mode_next  = a_mode_reg;
    a_rate_next  = a_rate_reg;
    a_lanes_next = a_lanes_reg;
    pend_next    = pend_reg;
    illegal_next = illegal_reg;
    ill_set      = 1'b0;
    rd_next      = 8'h00;
    case (link.addr)
      ADDR_STANDBY: rd_next = {7'h00, stby_reg};
      ADDR_MSTART:  rd_next = {7'h00, mst_n_reg};
      ADDR_MODE:    rd_next = {6'h00, a_mode_reg};
      ADDR_RATE:    rd_next = {6'h00, a_rate_reg};
      ADDR_LANES:   rd_next = {5'h00, a_lanes_reg};
      ADDR_HOLD:    rd_next = {7'h00, hold_reg};
      ADDR_ADC_W:   rd_next = {7'h00, a_adc_reg};
      ADDR_OUT_W:   rd_next = {7'h00, a_out_reg};
      ADDR_STATUS:  rd_next = status;
      default:      rd_next = 8'h00;
    endcase
    // Update point first, so a write in the same cycle stays pending
    if (upd && pend_reg) begin
      if (!stby_reg && ((p_adc_reg != a_adc_reg) || (p_out_reg != a_out_reg) ||
          (p_rate_reg != a_rate_reg) || (p_lanes_reg != a_lanes_reg) ||
          !soc_mode_direct(a_mode_reg, p_mode_reg)))
        ill_set = 1'b1;
      a_adc_next   = p_adc_reg;
      a_out_next   = p_out_reg;
      a_mode_next  = p_mode_reg;
      a_rate_next  = p_rate_reg;
      a_lanes_next = p_lanes_reg;
      pend_next    = 1'b0;
    end
    if (wr_ok) begin
      case (link.addr)
        ADDR_STANDBY: stby_next  = link.wr_data[0];
        ADDR_MSTART:  mst_n_next = link.wr_data[0];
        ADDR_HOLD:    hold_next  = link.wr_data[0];
        ADDR_STATUS:  illegal_next = illegal_next & ~link.wr_data[ST_ILLEGAL];
        default: ;
      endcase
      case (link.addr)
        ADDR_MODE:  p_mode_next  = link.wr_data[1:0];
        ADDR_RATE:  p_rate_next  = link.wr_data[1:0];
        ADDR_LANES: p_lanes_next = link.wr_data[2:0];
        ADDR_ADC_W: p_adc_next   = link.wr_data[0];
        ADDR_OUT_W: p_out_next   = link.wr_data[0];
        default: ;
      endcase
      if (link.addr == ADDR_MODE || link.addr == ADDR_RATE || link.addr == ADDR_LANES ||
          link.addr == ADDR_ADC_W || link.addr == ADDR_OUT_W)
        pend_next = 1'b1;
    end
    // A fresh mismatch sets the flag even while software clears it
    if (ill_set) illegal_next = 1'b1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      inclk_q_reg <= 1'b0;
      seen_reg    <= 1'b0;
      hold_reg    <= RST_HOLD;
      stby_reg    <= RST_STANDBY;
      mst_n_reg   <= RST_MSTART_N;
      p_adc_reg   <= RST_WIDTH;
      p_out_reg   <= RST_WIDTH;
      p_mode_reg  <= RST_MODE;
      p_rate_reg  <= RST_RATE;
      p_lanes_reg <= RST_LANES;
      a_adc_reg   <= RST_WIDTH;
      a_out_reg   <= RST_WIDTH;
      a_mode_reg  <= RST_MODE;
      a_rate_reg  <= RST_RATE;
      a_lanes_reg <= RST_LANES;
      pend_reg    <= 1'b0;
      illegal_reg <= 1'b0;
      rd_reg      <= 8'h00;
    end else begin
      inclk_q_reg <= link.input_clock;
      seen_reg    <= seen_next;
      hold_reg    <= hold_next;
      stby_reg    <= stby_next;
      mst_n_reg   <= mst_n_next;
      p_adc_reg   <= p_adc_next;
      p_out_reg   <= p_out_next;
      p_mode_reg  <= p_mode_next;
      p_rate_reg  <= p_rate_next;
      p_lanes_reg <= p_lanes_next;
      a_adc_reg   <= a_adc_next;
      a_out_reg   <= a_out_next;
      a_mode_reg  <= a_mode_next;
      a_rate_reg  <= a_rate_next;
      a_lanes_reg <= a_lanes_next;
      pend_reg    <= pend_next;
      illegal_reg <= illegal_next;
      rd_reg      <= rd_next;
    end
  end

  assign link.rd_data = rd_reg;
  assign mode_out     = a_mode_reg;
  assign rate_out     = a_rate_reg;
  assign lanes_out    = a_lanes_reg;
  assign standby_out  = stby_reg;

  // ----------------------------------------------------------------
  // Frame timing and sync sequencing
  // ----------------------------------------------------------------
  logic        run;
  logic [31:0] fcnt_reg,  fcnt_next;
  logic [2:0]  scnt_reg,  scnt_next;
  logic [2:0]  sidx;

  assign run  = ~stby_reg & master_mode_in & ~mst_n_reg;
  assign tick = run ? (fcnt_reg == 32'(FRAME_CYCLES - 1))
                    : (~stby_reg & ~master_mode_in & slave_vsync_in);
  assign sidx = SYNC_WORDS - scnt_reg;

  always_comb begin
    fcnt_next = 32'h0;
    if (run && !tick) fcnt_next = fcnt_reg + 32'h1;
    scnt_next = (scnt_reg != 3'h0) ? scnt_reg - 3'h1 : 3'h0;
    if (tick) scnt_next = SYNC_WORDS;
  end

  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      fcnt_reg <= 32'h0;
      scnt_reg <= 3'h0;
    end else begin
      fcnt_reg <= fcnt_next;
      scnt_reg <= scnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Output formatter
  // ----------------------------------------------------------------
  soc_pixel_fmt u_fmt (
    .sys_clk_in      (sys_clk_in),
    .srst_in         (clr),
    .wide_in         (a_out_reg),
    .sync_en_in      (scnt_reg != 3'h0),
    .sync_idx_in     (sidx[1:0]),
    .sample_in       (sample_in),
    .sample_valid_in (sample_valid_in & ~stby_reg),
    .word_out        (pix_word_out),
    .valid_out       (pix_valid_out),
    .sync_out        (pix_sync_out)
  );
endmodule : soc_device_end

// ---- soc_host_end.sv ----
`timescale 1ns/1ps
module soc_host_end
  import soc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  soc_if.host              link,
  input  wire logic        start_in,
  input  wire logic [3:0]  clk_div_in,
  input  wire logic        clk_change_in,
  input  wire logic        master_go_in,
  input  wire logic        master_stop_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_addr_in,
  input  wire logic [7:0]  cmd_data_in,
  output logic             cmd_ready_out,
  output logic             cmd_refused_out,
  output logic      [7:0]  dev_status_out
);
  typedef enum {H_OFF, H_CLEAR, H_CLKRUN, H_IDLE, H_WR2, H_STOP2, H_STOP3,
                H_REGWAIT, H_GO2, H_GO3} soc_host_st_t;

  soc_host_st_t st_reg, st_next;
  logic [7:0]   cnt_reg,   cnt_next;
  logic [3:0]   div_reg,   div_next;
  logic [3:0]   dcnt_reg,  dcnt_next;
  logic         ick_reg,   ick_next;
  logic         clr_n_reg, clr_n_next;
  logic         wv_reg,    wv_next;
  logic [7:0]   wa_reg,    wa_next;
  logic [7:0]   wd_reg,    wd_next;
  logic         stby_reg,  stby_next;
  logic [1:0]   mode_reg,  mode_next;
  logic         ref_next;
  logic         rdy_next;
  logic         needs_stby;

  always_comb begin
    needs_stby = (cmd_addr_in == ADDR_RATE) || (cmd_addr_in == ADDR_LANES) ||
                 (cmd_addr_in == ADDR_ADC_W) || (cmd_addr_in == ADDR_OUT_W) ||
                 (cmd_addr_in == ADDR_MODE && !soc_mode_direct(mode_reg, cmd_data_in[1:0]));
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    div_next   = div_reg;
    clr_n_next = clr_n_reg;
    wv_next    = 1'b0;
    wa_next    = ADDR_STATUS;
    wd_next    = 8'h00;
    stby_next  = stby_reg;
    mode_next  = mode_reg;
    ref_next   = 1'b0;
    rdy_next   = 1'b0;
    ick_next   = ick_reg;
    dcnt_next  = dcnt_reg;
    if (st_reg != H_OFF && st_reg != H_CLEAR) begin
      dcnt_next = (dcnt_reg == div_reg) ? 4'h0 : dcnt_reg + 4'h1;
      if (dcnt_reg == div_reg) ick_next = ~ick_reg;
    end else begin
      ick_next  = 1'b0;
      dcnt_next = 4'h0;
    end
    case (st_reg)
      H_OFF: if (start_in) begin
        st_next  = H_CLEAR;
        cnt_next = 8'(CLEAR_CYCLES);
      end
      H_CLEAR: begin
        clr_n_next = 1'b0;
        div_next   = clk_div_in;
        stby_next  = RST_STANDBY;
        mode_next  = RST_MODE;
        cnt_next   = cnt_reg - 8'h1;
        if (cnt_reg <= 8'h1) begin
          clr_n_next = 1'b1;
          st_next    = H_CLKRUN;
          cnt_next   = 8'(2 * CLK_WARMUP * (32'(clk_div_in) + 1));
        end
      end
      H_CLKRUN: begin
        cnt_next = cnt_reg - 8'h1;
        if (cnt_reg <= 8'h1) begin
          st_next  = H_IDLE;
          rdy_next = 1'b1;
        end
      end
      H_IDLE: begin
        rdy_next = 1'b1;
        if (clk_change_in) begin
          st_next    = H_CLEAR;
          cnt_next   = 8'(CLEAR_CYCLES);
          clr_n_next = 1'b0;
          ick_next   = 1'b0;
          dcnt_next  = 4'h0;
          rdy_next   = 1'b0;
        end else if (master_stop_in) begin
          {wv_next, wa_next, wd_next} = {1'b1, ADDR_STANDBY, 8'h01};
          stby_next = 1'b1;
          st_next   = H_STOP2;
          rdy_next  = 1'b0;
        end else if (master_go_in) begin
          {wv_next, wa_next, wd_next} = {1'b1, ADDR_STANDBY, 8'h00};
          stby_next = 1'b0;
          st_next   = H_REGWAIT;
          cnt_next  = 8'(REG_WAIT_CYCLES);
          rdy_next  = 1'b0;
        end else if (cmd_valid_in) begin
          if (needs_stby && !stby_reg) begin
            ref_next = 1'b1;
          end else begin
            {wv_next, wa_next, wd_next} = {1'b1, cmd_addr_in, cmd_data_in};
            if (cmd_addr_in == ADDR_MODE) mode_next = cmd_data_in[1:0];
            if (cmd_addr_in == ADDR_ADC_W || cmd_addr_in == ADDR_OUT_W) begin
              wa_next  = ADDR_ADC_W;
              wd_next  = {7'h00, cmd_data_in[0]};
              st_next  = H_WR2;
              rdy_next = 1'b0;
            end
          end
        end
      end
      H_WR2: begin
        {wv_next, wa_next} = {1'b1, ADDR_OUT_W};
        wd_next  = wd_reg;
        st_next  = H_IDLE;
        rdy_next = 1'b1;
      end
      H_STOP2: begin
        {wv_next, wa_next, wd_next} = {1'b1, ADDR_MSTART, 8'h01};
        st_next = H_STOP3;
      end
      H_STOP3: begin
        {wv_next, wa_next, wd_next} = {1'b1, ADDR_HOLD, 8'h01};
        st_next  = H_IDLE;
        rdy_next = 1'b1;
      end
      H_REGWAIT: begin
        cnt_next = cnt_reg - 8'h1;
        if (cnt_reg <= 8'h1) st_next = H_GO2;
      end
      H_GO2: begin
        {wv_next, wa_next, wd_next} = {1'b1, ADDR_MSTART, 8'h00};
        st_next = H_GO3;
      end
      H_GO3: begin
        {wv_next, wa_next, wd_next} = {1'b1, ADDR_HOLD, 8'h00};
        st_next  = H_IDLE;
        rdy_next = 1'b1;
      end
      default: st_next = H_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_reg          <= H_OFF;
      cnt_reg         <= 8'h00;
      div_reg         <= 4'h0;
      dcnt_reg        <= 4'h0;
      ick_reg         <= 1'b0;
      clr_n_reg       <= 1'b0;
      wv_reg          <= 1'b0;
      wa_reg          <= ADDR_STATUS;
      wd_reg          <= 8'h00;
      stby_reg        <= RST_STANDBY;
      mode_reg        <= RST_MODE;
      cmd_refused_out <= 1'b0;
      cmd_ready_out   <= 1'b0;
      dev_status_out  <= 8'h00;
    end else begin
      st_reg          <= st_next;
      cnt_reg         <= cnt_next;
      div_reg         <= div_next;
      dcnt_reg        <= dcnt_next;
      ick_reg         <= ick_next;
      clr_n_reg       <= clr_n_next;
      wv_reg          <= wv_next;
      wa_reg          <= wa_next;
      wd_reg          <= wd_next;
      stby_reg        <= stby_next;
      mode_reg        <= mode_next;
      cmd_refused_out <= ref_next;
      cmd_ready_out   <= rdy_next;
      dev_status_out  <= link.rd_data;
    end
  end

  assign link.system_clear_n = clr_n_reg;
  assign link.comm_enable_n  = ~wv_reg;
  assign link.input_clock    = ick_reg;
  assign link.wr_valid       = wv_reg;
  assign link.addr           = wa_reg;
  assign link.wr_data        = wd_reg;
endmodule : soc_host_end

// ---- soc_chk.sv ----
`timescale 1ns/1ps
module soc_chk
  import soc_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       srst_in,
  input wire logic       system_clear_n,
  input wire logic       comm_enable_n,
  input wire logic       input_clock,
  input wire logic       wr_valid,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // ------------------------------------------------
  // Link sequencing
  // ------------------------------------------------
  AST_CLR_LEN: assert property ($rose(system_clear_n) |->
    !$past(system_clear_n, 10) && !$past(system_clear_n, 5)) else $error("clear too short");
  AST_CE_IN_CLR: assert property (!system_clear_n |-> comm_enable_n)
    else $error("comm enable low in clear");
  AST_CLK_STILL: assert property (!system_clear_n && !$past(system_clear_n) |->
    $stable(input_clock)) else $error("clock runs in clear");
  AST_WR_AFTER_CLR: assert property (wr_valid |-> system_clear_n && !comm_enable_n)
    else $error("write outside setup");
  AST_DEFAULTS: assert property ($rose(system_clear_n) |-> ##2
    rd_data[ST_STANDBY] && rd_data[ST_WIDE] && !rd_data[ST_MASTER]) else $error("bad defaults");
  AST_WIDTH_STBY: assert property (wr_valid && addr == ADDR_ADC_W &&
    $past(addr) == ADDR_STATUS |-> rd_data[ST_STANDBY]) else $error("width write running");
  AST_WIDTH_PAIR: assert property (wr_valid && addr == ADDR_ADC_W |=> wr_valid &&
    addr == ADDR_OUT_W && wr_data == $past(wr_data)) else $error("width pair broken");
  AST_STOP_SEQ: assert property (wr_valid && addr == ADDR_STANDBY && wr_data[0] |->
    ##[1:3] wr_valid && addr == ADDR_MSTART && wr_data[0]) else $error("no master stop");
  cover property ($rose(system_clear_n));
  cover property (wr_valid && addr == ADDR_ADC_W);
  cover property (wr_valid && addr == ADDR_MSTART && !wr_data[0]);
endmodule : soc_chk

// ---- sensor_output_config_sequencer_tb.sv ----
`timescale 1ns/1ps
module sensor_output_config_sequencer_tb;
  import soc_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        start = 1'b0, go = 1'b0, stop = 1'b0, cv = 1'b0, vs = 1'b0, sv = 1'b0, ref_seen;
  logic        cc = 1'b0;
  wire logic [1:0]  md;
  logic [7:0]  ca = 8'h00, cd = 8'h00;
  logic [11:0] smp = 12'h000;
  wire logic        rdy, refused, pv, ps, stby;
  wire logic [7:0]  dst;
  wire logic [11:0] pw;
  logic [12:0] q[$];
  int          num_errors = 0, n_compared = 0, cyc = 0, sd;
  soc_if link_if();
  soc_host_end soc_host_end_inst(.sys_clk_in(sys_clk_in), .srst_in(srst_in), .link(link_if.host),
    .start_in(start), .clk_div_in(4'h1), .clk_change_in(cc), .master_go_in(go),
    .master_stop_in(stop), .cmd_valid_in(cv), .cmd_addr_in(ca), .cmd_data_in(cd),
    .cmd_ready_out(rdy), .cmd_refused_out(refused), .dev_status_out(dst));
  soc_device_end #(.FRAME_CYCLES(20)) soc_device_end_inst(.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .link(link_if.dev), .master_mode_in(1'b0), .slave_vsync_in(vs),
    .sample_in(smp), .sample_valid_in(sv), .pix_word_out(pw), .pix_valid_out(pv),
    .pix_sync_out(ps), .mode_out(md), .rate_out(), .lanes_out(), .standby_out(stby));
  soc_chk soc_chk_inst(.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .system_clear_n(link_if.system_clear_n), .comm_enable_n(link_if.comm_enable_n),
    .input_clock(link_if.input_clock), .wr_valid(link_if.wr_valid), .addr(link_if.addr),
    .wr_data(link_if.wr_data), .rd_data(link_if.rd_data));
  always #25 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic pulse(ref logic s, input int wait_n);
    @(negedge sys_clk_in) s = 1'b1;
    @(negedge sys_clk_in) s = 1'b0;
    repeat (wait_n) @(negedge sys_clk_in);
  endtask : pulse
  // Waits for ready, issues one request, catches the refusal flag one cycle later
  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    for (int i = 0; i < 300 && rdy !== 1'b1; i++) @(negedge sys_clk_in);
    cv = 1'b1;
    ca = a;
    cd = d;
    @(negedge sys_clk_in) cv = 1'b0;
    ref_seen = refused;
    repeat (6) @(negedge sys_clk_in);
  endtask : cmd
  task automatic frame(input logic w, input logic note);
    if (note) begin
      q.push_back({1'b1, w ? SYNC_ONES12 : SYNC_ONES10});
      q.push_back(13'h1000);
      q.push_back(13'h1000);
      q.push_back({1'b1, w ? SYNC_XY12 : SYNC_XY10});
    end
    pulse(vs, 10);
  endtask : frame
  task automatic samples(input logic w);
    logic [11:0] v, mx;
    for (int i = 0; i < 24; i++) begin
      @(negedge sys_clk_in) smp = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
      sv = 1'b1;
      v = w ? smp : {2'h0, smp[9:0]};
      mx = w ? PIX_MAX12 : PIX_MAX10;
      q.push_back({1'b0, (v < PIX_MIN) ? PIX_MIN : (v > mx) ? mx : v});
    end
    @(negedge sys_clk_in) sv = 1'b0;
    repeat (6) @(negedge sys_clk_in);
  endtask : samples
  always @(negedge sys_clk_in) begin
    if (!srst_in && pv === 1'b1) begin
      if (q.size() > 0) chk({ps, pw}, q.pop_front(), "pixel");
      else chk(pv, 1'b0, "unexpected pixel");
    end
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    sd = $urandom(32'h65e0);
    repeat (6) @(negedge sys_clk_in);
    srst_in = 1'b0;
    pulse(start, 1);
    cmd(ADDR_STATUS, 8'h00);
    chk({8'h00, dst[4:0]}, 13'h0011, "clear status");
    $display("test clear done");
    pulse(go, 60);
    chk(stby, 1'b0, "standby");
    frame(1'b1, 1'b1);
    samples(1'b1);
    cmd(ADDR_ADC_W, 8'h00);
    chk(ref_seen, 1'b1, "width refused");
    cmd(ADDR_MODE, 8'(MODE_ROI));
    chk(ref_seen, 1'b0, "direct mode");
    cmd(ADDR_MODE, 8'(MODE_FHD));
    chk(ref_seen, 1'b1, "mode refused");
    frame(1'b1, 1'b1);
    chk(md, 13'(MODE_ROI), "direct mode applied");
    $display("test run done");
    pulse(stop, 10);
    chk(stby, 1'b1, "standby");
    cmd(ADDR_ADC_W, 8'h00);
    chk(ref_seen, 1'b0, "width taken");
    chk(dst[ST_PENDING], 1'b1, "pending");
    pulse(go, 60);
    frame(1'b0, 1'b1);
    frame(1'b0, 1'b1);
    chk(dst[ST_WIDE], 1'b0, "width applied");
    samples(1'b0);
    $display("test width done");
    pulse(cc, 1);
    cmd(ADDR_STATUS, 8'h00);
    chk({8'h00, dst[4:0]}, 13'h0011, "reclear status");
    $display("test reclear done");
    close_out();
  end
endmodule : sensor_output_config_sequencer_tb
